// File: acr_pkg.sv
// Shared constants and types for the ADC alarm and thermal charge register slice
package acr_pkg;
    // Register offsets on the serial register bus
    localparam logic [7:0] ACR_ALARM3_HI_OFS = 8'h56;
    localparam logic [7:0] ACR_ALARM3_LO_OFS = 8'h57;
    localparam logic [7:0] ACR_CHAN_EN_OFS = 8'h58;
    localparam logic [7:0] ACR_DERATE_OFS = 8'h61;
    localparam logic [7:0] ACR_COLD_OFS = 8'h62;
    localparam logic [7:0] ACR_COOL_OFS = 8'h63;
    localparam logic [7:0] ACR_WARM_OFS = 8'h64;
    localparam logic [7:0] ACR_HOT_OFS = 8'h65;
    // Values after reset
    localparam logic [7:0] ACR_ALARM3_HI_RST = 8'h00;
    localparam logic [7:0] ACR_ALARM3_LO_RST = 8'h00;
    localparam logic [7:0] ACR_CHAN_EN_RST = 8'h00;
    localparam logic [7:0] ACR_DERATE_RST = 8'h34;
    localparam logic [7:0] ACR_COLD_RST = 8'h7c;
    localparam logic [7:0] ACR_COOL_RST = 8'h6d;
    localparam logic [7:0] ACR_WARM_RST = 8'h38;
    localparam logic [7:0] ACR_HOT_RST = 8'h27;
    // Field positions
    localparam int ACR_NIBBLE_MSB = 7;
    localparam int ACR_NIBBLE_LSB = 4;
    localparam int ACR_POLARITY_BIT = 3;
    localparam int ACR_VDROP_MSB = 6;
    localparam int ACR_VDROP_LSB = 4;
    localparam int ACR_ISCALE_MSB = 2;
    localparam int ACR_ISCALE_LSB = 0;
    // Voltage step of the warm drop, and full current in eighths
    localparam logic [5:0] ACR_VDROP_STEP_MV = 6'h32;
    localparam logic [3:0] ACR_FULL_EIGHTHS = 4'h8;
    // Serial bus byte length in bits
    localparam logic [3:0] ACR_BYTE_BITS = 4'h8;

    typedef enum logic [2:0] {
        ACR_IDLE = 3'b000,
        ACR_ADDR = 3'b001,
        ACR_ACK = 3'b011,
        ACR_REG = 3'b010,
        ACR_WDATA = 3'b110,
        ACR_RDATA = 3'b111,
        ACR_RACK = 3'b101
    } acr_state_e;

    typedef struct packed {
        logic valid;
        logic [15:0] value;
    } acr_meas_s;

    typedef struct packed {
        logic input_current_meas_en;
        logic system_rail_meas_en;
        logic charge_current_meas_en;
        logic input_voltage_meas_en;
        logic battery_voltage_meas_en;
        logic thermistor_meas_en;
        logic aux_input_meas_en;
    } acr_chan_s;

    typedef struct packed {
        logic [7:0] cold_level;
        logic [7:0] cool_level;
        logic [7:0] warm_level;
        logic [7:0] hot_level;
    } acr_therm_s;
endpackage : acr_pkg

// File: acr_regs.sv
// Register slice: serial target, alarm 3, channel enables, thermal derating
`timescale 1ns/1ps
`default_nettype none
module acr_regs
    import acr_pkg::*;
#(
    parameter logic [6:0] TARGET_ADDR = 7'h2a // Arbitrary bus address
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n_out,
    input wire acr_meas_s meas_in,
    input wire logic warm_region_in,
    input wire logic derate_active_in,
    output acr_chan_s chan_en_out,
    output acr_therm_s thermistor_levels_out,
    output logic [8:0] warm_voltage_drop_out,
    output logic [3:0] thermal_current_scale_out,
    output logic alarm3_event_out
);
    // Pin synchronisers and edge history
    logic scl_m_r, scl_s_r, scl_d_r, sda_m_r, sda_s_r, sda_d_r;
    acr_state_e state_r;
    acr_state_e after_ack_r;
    logic [3:0] cnt_r;
    logic [7:0] sh_r, tx_r, ptr_r;
    logic drive_r, rw_r, wr_stb_r;
    logic [7:0] wr_addr_r, wr_data_r;
    logic [7:0] alarm3_hi_r, alarm3_lo_r, chan_en_r, derate_r;
    logic [7:0] cold_r, cool_r, warm_r, hot_r;
    logic prev_below_r, prev_above_r, alarm_r;
    logic [8:0] vdrop_r;
    logic [3:0] iscale_r;

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            {scl_m_r, scl_s_r, scl_d_r} <= 3'h7;
            {sda_m_r, sda_s_r, sda_d_r} <= 3'h7;
        end else begin
            {scl_m_r, scl_s_r, scl_d_r} <= {scl_in, scl_m_r, scl_s_r};
            {sda_m_r, sda_s_r, sda_d_r} <= {sda_in, sda_m_r, sda_s_r};
        end
    end

    // Bus conditions from synchronised pins
    wire start_w = scl_s_r && scl_d_r && sda_d_r && !sda_s_r;
    wire stop_w = scl_s_r && scl_d_r && !sda_d_r && sda_s_r;
    wire scl_rise_w = scl_s_r && !scl_d_r;
    wire scl_fall_w = !scl_s_r && scl_d_r;
    wire byte_done_w = (cnt_r == ACR_BYTE_BITS);
    wire addr_hit_w = (sh_r[7:1] == TARGET_ADDR);

    // Read data selection by register pointer
    wire hit_hi_w = (ptr_r == ACR_ALARM3_HI_OFS);
    wire hit_lo_w = (ptr_r == ACR_ALARM3_LO_OFS);
    wire hit_en_w = (ptr_r == ACR_CHAN_EN_OFS);
    wire hit_dr_w = (ptr_r == ACR_DERATE_OFS);
    wire hit_cd_w = (ptr_r == ACR_COLD_OFS);
    wire hit_cl_w = (ptr_r == ACR_COOL_OFS);
    wire hit_wm_w = (ptr_r == ACR_WARM_OFS);
    wire hit_ht_w = (ptr_r == ACR_HOT_OFS);
    wire [7:0] rdata_w = ({8{hit_hi_w}} & alarm3_hi_r) | ({8{hit_lo_w}} & alarm3_lo_r)
        | ({8{hit_en_w}} & chan_en_r) | ({8{hit_dr_w}} & derate_r)
        | ({8{hit_cd_w}} & cold_r) | ({8{hit_cl_w}} & cool_r)
        | ({8{hit_wm_w}} & warm_r) | ({8{hit_ht_w}} & hot_r);

    // Serial target sequencer: address, pointer, write or read bytes
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            state_r <= ACR_IDLE;
            after_ack_r <= ACR_IDLE;
            cnt_r <= 4'h0;
            sh_r <= 8'h00;
            tx_r <= 8'h00;
            ptr_r <= 8'h00;
            drive_r <= 1'b0;
            rw_r <= 1'b0;
            wr_stb_r <= 1'b0;
            wr_addr_r <= 8'h00;
            wr_data_r <= 8'h00;
        end else begin
            wr_stb_r <= 1'b0;
            if (start_w) begin
                state_r <= ACR_ADDR;
                cnt_r <= 4'h0;
                drive_r <= 1'b0;
            end else if (stop_w) begin
                state_r <= ACR_IDLE;
                drive_r <= 1'b0;
            end else if (scl_rise_w) begin
                case (state_r)
                    ACR_ADDR, ACR_REG, ACR_WDATA: begin
                        sh_r <= {sh_r[6:0], sda_s_r};
                        cnt_r <= cnt_r + 4'h1;
                    end
                    ACR_RDATA: cnt_r <= cnt_r + 4'h1;
                    ACR_RACK: rw_r <= !sda_s_r; // Controller ack keeps the read going
                    default: ;
                endcase
            end else if (scl_fall_w) begin
                case (state_r)
                    ACR_ADDR: begin
                        if (byte_done_w && addr_hit_w) begin
                            rw_r <= sh_r[0];
                            drive_r <= 1'b1;
                            state_r <= ACR_ACK;
                            after_ack_r <= sh_r[0] ? ACR_RDATA : ACR_REG;
                        end else if (byte_done_w) begin
                            state_r <= ACR_IDLE;
                        end
                    end
                    ACR_REG, ACR_WDATA: begin
                        if (byte_done_w) begin
                            drive_r <= 1'b1;
                            state_r <= ACR_ACK;
                            after_ack_r <= ACR_WDATA;
                            if (state_r == ACR_REG) begin
                                ptr_r <= sh_r;
                            end else begin
                                wr_stb_r <= 1'b1;
                                wr_addr_r <= ptr_r;
                                wr_data_r <= sh_r;
                                ptr_r <= ptr_r + 8'h01;
                            end
                        end
                    end
                    ACR_ACK, ACR_RACK: begin
                        cnt_r <= 4'h0;
                        if (after_ack_r == ACR_RDATA && (state_r == ACR_ACK || rw_r)) begin
                            state_r <= ACR_RDATA;
                            tx_r <= rdata_w;
                            drive_r <= !rdata_w[7];
                            ptr_r <= ptr_r + 8'h01;
                        end else begin
                            drive_r <= 1'b0;
                            state_r <= (state_r == ACR_RACK) ? ACR_IDLE : after_ack_r;
                        end
                    end
                    ACR_RDATA: begin
                        if (byte_done_w) begin
                            drive_r <= 1'b0;
                            state_r <= ACR_RACK;
                        end else begin
                            tx_r <= {tx_r[6:0], 1'b0};
                            drive_r <= !tx_r[6];
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // Open drain data pin: enable low pulls the line low
    assign sda_out = 1'b0;
    assign sda_oe_n_out = !drive_r;

    // Register write decode
    wire wr_hi_w = wr_stb_r && (wr_addr_r == ACR_ALARM3_HI_OFS);
    wire wr_lo_w = wr_stb_r && (wr_addr_r == ACR_ALARM3_LO_OFS);
    wire wr_en_w = wr_stb_r && (wr_addr_r == ACR_CHAN_EN_OFS);
    wire wr_dr_w = wr_stb_r && (wr_addr_r == ACR_DERATE_OFS);
    wire wr_cd_w = wr_stb_r && (wr_addr_r == ACR_COLD_OFS);
    wire wr_cl_w = wr_stb_r && (wr_addr_r == ACR_COOL_OFS);
    wire wr_wm_w = wr_stb_r && (wr_addr_r == ACR_WARM_OFS);
    wire wr_ht_w = wr_stb_r && (wr_addr_r == ACR_HOT_OFS);

    // Register storage, all bits read/write including reserved ones
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            alarm3_hi_r <= ACR_ALARM3_HI_RST;
            alarm3_lo_r <= ACR_ALARM3_LO_RST;
            chan_en_r <= ACR_CHAN_EN_RST;
            derate_r <= ACR_DERATE_RST;
            cold_r <= ACR_COLD_RST;
            cool_r <= ACR_COOL_RST;
            warm_r <= ACR_WARM_RST;
            hot_r <= ACR_HOT_RST;
        end else begin
            if (wr_hi_w) alarm3_hi_r <= wr_data_r;
            if (wr_lo_w) alarm3_lo_r <= wr_data_r;
            if (wr_en_w) chan_en_r <= wr_data_r;
            if (wr_dr_w) derate_r <= wr_data_r;
            if (wr_cd_w) cold_r <= wr_data_r;
            if (wr_cl_w) cool_r <= wr_data_r;
            if (wr_wm_w) warm_r <= wr_data_r;
            if (wr_ht_w) hot_r <= wr_data_r;
        end
    end

    // Channel enables and thermistor levels straight from flops
    assign chan_en_out = acr_chan_s'(chan_en_r[7:1]);
    assign thermistor_levels_out = {cold_r, cool_r, warm_r, hot_r};

    // Alarm 3 comparison against measurement bits 15:4
    wire [11:0] alarm3_thr_w = {alarm3_hi_r, alarm3_lo_r[ACR_NIBBLE_MSB:ACR_NIBBLE_LSB]};
    wire polarity_w = alarm3_lo_r[ACR_POLARITY_BIT];
    wire below_w = meas_in.value[15:4] < alarm3_thr_w;
    wire above_w = meas_in.value[15:4] > alarm3_thr_w;
    wire cross_w = meas_in.valid && (polarity_w ? (above_w && !prev_above_r)
        : (below_w && !prev_below_r));

    // Thermal derating values
    wire [2:0] vdrop_code_w = derate_r[ACR_VDROP_MSB:ACR_VDROP_LSB];
    wire [2:0] iscale_code_w = derate_r[ACR_ISCALE_MSB:ACR_ISCALE_LSB];
    wire [8:0] vdrop_mv_w = {6'h00, vdrop_code_w} * {3'h0, ACR_VDROP_STEP_MV};
    wire [3:0] iscale_w = ACR_FULL_EIGHTHS - {1'b0, iscale_code_w};

    // Crossing history and registered outputs
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            prev_below_r <= 1'b0;
            prev_above_r <= 1'b0;
            alarm_r <= 1'b0;
            vdrop_r <= 9'h000;
            iscale_r <= ACR_FULL_EIGHTHS;
        end else begin
            alarm_r <= cross_w;
            if (meas_in.valid) begin
                prev_below_r <= below_w;
                prev_above_r <= above_w;
            end
            vdrop_r <= warm_region_in ? vdrop_mv_w : 9'h000;
            iscale_r <= derate_active_in ? iscale_w : ACR_FULL_EIGHTHS;
        end
    end

    assign alarm3_event_out = alarm_r;
    assign warm_voltage_drop_out = vdrop_r;
    assign thermal_current_scale_out = iscale_r;

    // Checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    property p_thr_reset;
        $rose(reset_n_in) |-> cold_r == 8'h7c && cool_r == 8'h6d && warm_r == 8'h38
            && hot_r == 8'h27;
    endproperty
    a_thr_reset: assert property (p_thr_reset) else $error("threshold reset value");

    property p_ctl_reset;
        $rose(reset_n_in) |-> chan_en_r == 8'h00 && derate_r == 8'h34 && alarm3_lo_r == 8'h00;
    endproperty
    a_ctl_reset: assert property (p_ctl_reset) else $error("control reset value");

    property p_chan_write;
        wr_en_w |=> chan_en_out == $past(wr_data_r[7:1]);
    endproperty
    a_chan_write: assert property (p_chan_write) else $error("channel enable write");

    property p_hi_write;
        wr_hi_w |=> alarm3_thr_w[11:4] == $past(wr_data_r);
    endproperty
    a_hi_write: assert property (p_hi_write) else $error("alarm high byte");

    property p_lo_write;
        wr_lo_w |=> alarm3_thr_w[3:0] == $past(wr_data_r[7:4]) && polarity_w == $past(wr_data_r[3]);
    endproperty
    a_lo_write: assert property (p_lo_write) else $error("alarm low nibble");

    property p_fall_alarm;
        meas_in.valid && !polarity_w && below_w && !prev_below_r |=> alarm3_event_out;
    endproperty
    a_fall_alarm: assert property (p_fall_alarm) else $error("falling alarm missed");

    property p_no_repeat;
        meas_in.valid && !polarity_w && prev_below_r && !above_w ##1 !wr_stb_r |-> !alarm3_event_out;
    endproperty
    a_no_repeat: assert property (p_no_repeat) else $error("alarm without crossing");

    property p_vdrop;
        warm_region_in |=> warm_voltage_drop_out == {6'h00, $past(vdrop_code_w)} * 9'h032;
    endproperty
    a_vdrop: assert property (p_vdrop) else $error("warm drop value");

    property p_iscale;
        derate_active_in && iscale_code_w == 3'h4 |=> thermal_current_scale_out == 4'h4;
    endproperty
    a_iscale: assert property (p_iscale) else $error("current scale value");

    property p_idle_quiet;
        state_r == ACR_IDLE && !scl_fall_w |=> sda_oe_n_out;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("pin driven while idle");

    c_write: cover property (wr_stb_r);
    c_read: cover property (state_r == ACR_RDATA && scl_fall_w);
    c_rise_alarm: cover property (polarity_w && alarm3_event_out);
endmodule : acr_regs
`default_nettype wire

// File: acr_host.sv
// Bus controller model that drives the serial register bus of the slice
`timescale 1ns/1ps
`default_nettype none
module acr_host (
    input wire logic clk_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_oe_n_out
);
    int half = 5; // Phase length in clocks, never below 4

    // Idle bus: clock high, data released
    initial begin
        scl_out = 1'b1;
        sda_oe_n_out = 1'b1;
    end

    // Wait a number of clocks
    task automatic hc(input int n);
        repeat (n) @(posedge clk_in);
    endtask : hc

    // Start or repeated start: data falls while clock high
    task automatic start();
        scl_out <= 1'b0;
        hc(2);
        sda_oe_n_out <= 1'b1;
        hc(half);
        scl_out <= 1'b1;
        hc(half);
        sda_oe_n_out <= 1'b0;
        hc(half);
        scl_out <= 1'b0;
        hc(2);
    endtask : start

    // Stop: data rises while clock high, then bus released
    task automatic stop();
        sda_oe_n_out <= 1'b0;
        hc(half);
        scl_out <= 1'b1;
        hc(half);
        sda_oe_n_out <= 1'b1;
        hc(half);
    endtask : stop

    // One bit; data held steady over the whole clock high phase
    task automatic xbit(input logic b, output logic s);
        sda_oe_n_out <= b;
        hc(half);
        scl_out <= 1'b1;
        hc(half);
        s = sda_in;
        scl_out <= 1'b0;
        hc(2);
    endtask : xbit

    // Byte out, msb first, then the target's acknowledge
    task automatic wbyte(input logic [7:0] d, output logic ack_n);
        logic s;
        for (int i = 7; i >= 0; i--) xbit(d[i], s);
        xbit(1'b1, ack_n);
    endtask : wbyte

    // Byte in, msb first; last byte is not acknowledged
    task automatic rbyte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) xbit(1'b1, d[i]);
        xbit(last, s);
    endtask : rbyte
endmodule : acr_host
`default_nettype wire

// File: acr_regs_tb_top.sv
// Self-checking bench for the alarm and thermal register slice
`timescale 1ns/1ps
`default_nettype none
module acr_regs_tb_top
    import acr_pkg::*;
;
    localparam logic [6:0] TA = 7'h2a;
    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    acr_meas_s meas_in = '0;
    logic warm_region_in = 1'b0;
    logic derate_active_in = 1'b0;
    logic scl, host_oe_n, dut_sda, dut_oe_n, alarm;
    wire logic sda_line;
    acr_chan_s chan_en;
    acr_therm_s levels;
    logic [8:0] drop;
    logic [3:0] scale;
    int n_errors = 0;
    int n_compared = 0;
    logic [7:0] ofs [8] = '{8'h56, 8'h57, 8'h58, 8'h61, 8'h62, 8'h63, 8'h64, 8'h65};
    logic [7:0] rst [8] = '{8'h00, 8'h00, 8'h00, 8'h34, 8'h7c, 8'h6d, 8'h38, 8'h27};
    int dv [9] = '{1, -1, -1, 0, -1, 1, 1, 0, 1};

    // Open-drain data line with pull-up
    assign sda_line = host_oe_n & (dut_oe_n | dut_sda);
    always #10 clk_in = ~clk_in;

    acr_regs uut (.clk_in(clk_in), .reset_n_in(reset_n_in), .scl_in(scl), .sda_in(sda_line),
        .sda_out(dut_sda), .sda_oe_n_out(dut_oe_n), .meas_in(meas_in),
        .warm_region_in(warm_region_in), .derate_active_in(derate_active_in),
        .chan_en_out(chan_en), .thermistor_levels_out(levels), .warm_voltage_drop_out(drop),
        .thermal_current_scale_out(scale), .alarm3_event_out(alarm));
    acr_host host (.clk_in(clk_in), .sda_in(sda_line), .scl_out(scl), .sda_oe_n_out(host_oe_n));

    // Expected alarm pulse from polarity, value, threshold and history
    function automatic int exp_alarm(logic pol, logic [11:0] v, logic [11:0] t, int prev);
        return pol ? int'(v > t && prev != 1) : int'(v < t && prev != -1);
    endfunction : exp_alarm
    // Expected derated outputs
    function automatic logic [8:0] exp_drop(logic w, int c);
        return w ? 9'(c * 50) : 9'h000;
    endfunction : exp_drop
    function automatic logic [3:0] exp_scale(logic a, int c);
        return a ? 4'(8 - c) : 4'h8;
    endfunction : exp_scale

    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask : chk

    // Register write: address, pointer, data
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic k;
        host.start();
        host.wbyte({TA, 1'b0}, k);
        host.wbyte(a, k);
        host.wbyte(d, k);
        host.stop();
        chk("write ack", 32'h0, 32'(k));
    endtask : wr

    // Register read through repeated start
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        logic k;
        host.start();
        host.wbyte({TA, 1'b0}, k);
        host.wbyte(a, k);
        host.start();
        host.wbyte({TA, 1'b1}, k);
        host.rbyte(1'b1, d);
        host.stop();
    endtask : rd

    // One measurement pulse; count alarm pulses that follow
    task automatic meas(input logic [11:0] v, output int n);
        n = 0;
        meas_in <= {1'b1, v, 4'($urandom)};
        @(posedge clk_in);
        meas_in.valid <= 1'b0;
        repeat (4) begin
            @(posedge clk_in);
            n += int'(alarm !== 1'b0);
        end
    endtask : meas

    initial begin
        repeat (90000) @(posedge clk_in);
        n_errors++;
        end_sim();
    end

    initial begin
        logic [7:0] d;
        logic [7:0] v [8];
        logic [11:0] t;
        logic k;
        int n, prev;
        d = 8'($urandom(32'he1de));
        repeat (16) @(posedge clk_in);
        reset_n_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        chk("chan_en", 32'h0, 32'(chan_en));
        chk("levels", 32'h7c6d3827, levels);
        chk("scale", 32'h8, 32'(scale));
        chk("drop", 32'h0, 32'(drop));
        for (int i = 0; i < 8; i++) begin
            rd(ofs[i], d);
            chk("reset value", 32'(rst[i]), 32'(d));
        end
        $display("test reset done");
        host.half = 9;
        for (int i = 0; i < 8; i++) begin
            v[i] = 8'($urandom);
            wr(ofs[i], v[i]);
        end
        for (int i = 0; i < 8; i++) begin
            rd(ofs[i], d);
            chk("readback", 32'(v[i]), 32'(d));
        end
        chk("chan_en", 32'(v[2][7:1]), 32'(chan_en));
        chk("levels", {v[4], v[5], v[6], v[7]}, levels);
        // Two-byte read: controller ack continues, pointer steps to the next register
        host.start();
        host.wbyte({TA, 1'b0}, k);
        host.wbyte(ACR_WARM_OFS, k);
        host.start();
        host.wbyte({TA, 1'b1}, k);
        host.rbyte(1'b0, d);
        chk("burst first", 32'(v[6]), 32'(d));
        host.rbyte(1'b1, d);
        chk("burst second", 32'(v[7]), 32'(d));
        host.stop();
        host.half = 5;
        $display("test readback done");
        wr(8'h60, 8'($urandom));
        rd(8'h60, d);
        chk("unmapped", 32'h0, 32'(d));
        host.start();
        host.wbyte({7'h15, 1'b0}, k);
        host.stop();
        chk("foreign ack", 32'h1, 32'(k));
        $display("test refused done");
        for (int c = 0; c < 8; c++) begin
            wr(ACR_DERATE_OFS, {1'($urandom), 3'(c), 1'($urandom), 3'(7 - c)});
            warm_region_in <= 1'($urandom);
            derate_active_in <= 1'($urandom);
            repeat (3) @(posedge clk_in);
            chk("drop", 32'(exp_drop(warm_region_in, c)), 32'(drop));
            chk("scale", 32'(exp_scale(derate_active_in, 7 - c)), 32'(scale));
        end
        $display("test derate done");
        t = 12'($urandom_range(12'hfee, 12'h011));
        wr(ACR_ALARM3_HI_OFS, t[11:4]);
        wr(ACR_ALARM3_LO_OFS, {t[3:0], 4'h0});
        prev = 0;
        for (int i = 0; i < 9; i++) begin
            if (i == 5) begin
                wr(ACR_ALARM3_LO_OFS, {t[3:0], 4'h8});
            end
            meas(12'(t + 12'(dv[i])), n);
            chk("alarm", 32'(exp_alarm(i >= 5, 12'(t + 12'(dv[i])), t, prev)), 32'(n));
            prev = dv[i];
        end
        $display("test alarm done");
        end_sim();
    end
endmodule : acr_regs_tb_top
`default_nettype wire
